// >>> include/ssc_pkg.sv
// Purpose: Constants and types for the serial control-low and enable registers
// Assumes: Byte-wide register port, 8-bit offsets
// Notes:   Offsets are byte addresses on the plain register port
`default_nettype none
package ssc_pkg;
	localparam logic [7:0] CTRL_LOW_OFFSET   = 8'hB9;
	localparam logic [7:0] ENABLE_OFFSET     = 8'hBB;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'hC0;
	localparam logic [7:0] IRQ_MASK_OFFSET   = 8'hC1;
	localparam logic [7:0] CTRL_LOW_RESET    = 8'h7D;
	localparam logic [7:0] ENABLE_RESET      = 8'h00;
	localparam logic [7:0] IRQ_MASK_RESET    = 8'h00;
	// Control-low fields
	localparam int SOFT_RESET_POS  = 1;
	localparam int WRITE_PROT_POS  = 4;
	localparam int IDLE_LEVEL_POS  = 5;
	localparam logic IDLE_LEVEL_RESET = 1'b1;
	// Enable fields
	localparam int CONFLICT_IE_POS = 0;
	localparam int RECV_EN_POS     = 3;
	localparam int XMIT_EN_POS     = 4;
	localparam int RECV_IE_POS     = 5;
	localparam int XEND_IE_POS     = 6;
	localparam int XEMPTY_IE_POS   = 7;
	localparam logic [7:0] ENABLE_USED_MASK = 8'hF9;
	// Event positions in status and mask registers
	localparam int EV_CONFLICT = 0;
	localparam int EV_OVERRUN  = 1;
	localparam int EV_RECV_FULL = 2;
	localparam int EV_XMIT_END = 3;
	localparam int EV_XMIT_EMPTY = 4;
	localparam int EV_COUNT    = 5;

	typedef struct packed {
		logic conflict;
		logic overrun;
		logic recv_full;
		logic xmit_end;
		logic xmit_empty;
	} ssc_flags_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       write;
		logic       read;
	} ssc_bus_type;
endpackage
`default_nettype wire

// >>> src/ssc_regs.sv
// Purpose: Control-low and enable registers of the synchronous serial unit, with interrupt gating
// Assumes: Flags and transfer activity come from the shift engine; inputs synchronous to clock
// Notes:   Soft reset is a one-cycle strobe; register contents are never touched by it
//
// Behaviour
// - Soft-reset write pulses engine reset for one cycle
// - Soft reset leaves all registers unchanged
// - Idle level written only with protect zero
// - Write-protect bit unstored, reads as one
// - Idle level read shows live output level
// - Permitted write sets idle output after transfer
// - Conflict enable gates conflict request
// - Receive enable bit enables reception
// - Transmit enable bit enables transmission
// - Receive interrupt enable gates full and overrun
// - Transmit-end enable gates transmit-end request
// - Transmit-empty enable gates transmit-empty request
// - Unassigned enable bits read as zero
// - All five sources share one request
`default_nettype none
module ssc_regs (
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	input  wire ssc_pkg::ssc_bus_type  bus,
	output logic [7:0]                 rdata,
	input  wire ssc_pkg::ssc_flags_type flags,
	input  wire logic                  transfer_active,
	input  wire logic                  shift_data_out,
	output logic                       serial_data_out,
	output logic                       engine_reset,
	output logic                       receive_enable,
	output logic                       transmit_enable,
	output logic                       serial_irq_request,
	output logic                       irq
);
	logic       rst_meta;
	logic       rst_sync_b;
	logic       idle_level;
	logic [7:0] enable_reg;
	logic [4:0] irq_status;
	logic [4:0] irq_mask;
	logic       soft_reset_pulse;
	logic       flags_prev_any;
	ssc_pkg::ssc_flags_type flags_prev;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta   <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_b <= rst_meta;
		end
	end

	wire wr_ctrl   = bus.write && (bus.addr == ssc_pkg::CTRL_LOW_OFFSET);
	wire wr_enable = bus.write && (bus.addr == ssc_pkg::ENABLE_OFFSET);
	wire wr_status = bus.write && (bus.addr == ssc_pkg::IRQ_STATUS_OFFSET);
	wire wr_mask   = bus.write && (bus.addr == ssc_pkg::IRQ_MASK_OFFSET);

	// Level change is accepted only when protect is cleared in the same write
	wire idle_write_ok = wr_ctrl && !bus.wdata[ssc_pkg::WRITE_PROT_POS];
	wire next_soft_reset = wr_ctrl && bus.wdata[ssc_pkg::SOFT_RESET_POS];

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			idle_level       <= ssc_pkg::IDLE_LEVEL_RESET;
			soft_reset_pulse <= 1'b0;
		end else begin
			soft_reset_pulse <= next_soft_reset;
			if (idle_write_ok) begin
				idle_level <= bus.wdata[ssc_pkg::IDLE_LEVEL_POS];
			end
		end
	end

	// Soft reset never reaches these registers, only the engine strobe
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			enable_reg <= ssc_pkg::ENABLE_RESET;
			irq_mask   <= ssc_pkg::IRQ_MASK_RESET[4:0];
		end else begin
			if (wr_enable) begin
				enable_reg <= bus.wdata & ssc_pkg::ENABLE_USED_MASK;
			end
			if (wr_mask) begin
				irq_mask <= bus.wdata[4:0];
			end
		end
	end

	assign engine_reset    = soft_reset_pulse;
	assign receive_enable  = enable_reg[ssc_pkg::RECV_EN_POS];
	assign transmit_enable = enable_reg[ssc_pkg::XMIT_EN_POS];

	// Between transfers the pin holds the programmed idle level
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			serial_data_out <= ssc_pkg::IDLE_LEVEL_RESET;
		end else begin
			serial_data_out <= transfer_active ? shift_data_out : idle_level;
		end
	end

	wire gate_conflict = flags.conflict   && enable_reg[ssc_pkg::CONFLICT_IE_POS];
	wire gate_overrun  = flags.overrun    && enable_reg[ssc_pkg::RECV_IE_POS];
	wire gate_full     = flags.recv_full  && enable_reg[ssc_pkg::RECV_IE_POS];
	wire gate_end      = flags.xmit_end   && enable_reg[ssc_pkg::XEND_IE_POS];
	wire gate_empty    = flags.xmit_empty && enable_reg[ssc_pkg::XEMPTY_IE_POS];
	wire [4:0] gated   = {gate_empty, gate_end, gate_full, gate_overrun, gate_conflict};
	assign serial_irq_request = |gated;

	// Rising edges of gated requests are the sticky events; set beats clear
	logic [4:0] gated_prev;
	wire  [4:0] rise = gated & ~gated_prev;
	wire  [4:0] next_status = (irq_status & ~(wr_status ? bus.wdata[4:0] : 5'h00)) | rise;

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			gated_prev <= 5'h00;
			irq_status <= 5'h00;
		end else begin
			gated_prev <= gated;
			irq_status <= next_status;
		end
	end

	assign irq = |(irq_status & irq_mask);

	wire [7:0] ctrl_view = (8'h00 | (8'h01 << ssc_pkg::WRITE_PROT_POS))
		| ({7'h00, serial_data_out} << ssc_pkg::IDLE_LEVEL_POS);
	wire [7:0] next_rdata =
		(bus.addr == ssc_pkg::CTRL_LOW_OFFSET)   ? ctrl_view :
		(bus.addr == ssc_pkg::ENABLE_OFFSET)     ? enable_reg :
		(bus.addr == ssc_pkg::IRQ_STATUS_OFFSET) ? {3'h0, irq_status} :
		(bus.addr == ssc_pkg::IRQ_MASK_OFFSET)   ? {3'h0, irq_mask} : 8'h00;

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rdata <= 8'h00;
		end else begin
			rdata <= bus.read ? next_rdata : 8'h00;
		end
	end

	// Checks
	property p_soft_reset;
		@(posedge clock) disable iff (!rst_sync_b)
		next_soft_reset |=> engine_reset ##1 !engine_reset || next_soft_reset;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset strobe wrong");

	property p_keep_enable;
		@(posedge clock) disable iff (!rst_sync_b)
		(next_soft_reset && !wr_enable) |=> $stable(enable_reg);
	endproperty
	a_keep_enable: assert property (p_keep_enable) else $error("soft reset disturbed enable");

	property p_protected;
		@(posedge clock) disable iff (!rst_sync_b)
		(wr_ctrl && bus.wdata[ssc_pkg::WRITE_PROT_POS]) |=> $stable(idle_level);
	endproperty
	a_protected: assert property (p_protected) else $error("protected idle level changed");

	sequence s_idle_write;
		idle_write_ok && !transfer_active;
	endsequence
	property p_idle_drive;
		@(posedge clock) disable iff (!rst_sync_b)
		s_idle_write ##1 !transfer_active |=> serial_data_out == $past(idle_level);
	endproperty
	a_idle_drive: assert property (p_idle_drive) else $error("idle level not driven");

	property p_read_ctrl;
		@(posedge clock) disable iff (!rst_sync_b)
		(bus.read && bus.addr == ssc_pkg::CTRL_LOW_OFFSET) |=>
			rdata[ssc_pkg::WRITE_PROT_POS] && rdata[ssc_pkg::IDLE_LEVEL_POS] == $past(serial_data_out);
	endproperty
	a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong");

	property p_reserved;
		@(posedge clock) disable iff (!rst_sync_b)
		(bus.read && bus.addr == ssc_pkg::ENABLE_OFFSET) |=> rdata[2:1] == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved enable bits nonzero");

	property p_recv_gate;
		@(posedge clock) disable iff (!rst_sync_b)
		!enable_reg[ssc_pkg::RECV_IE_POS] && !flags.conflict && !flags.xmit_end && !flags.xmit_empty
			|-> !serial_irq_request;
	endproperty
	a_recv_gate: assert property (p_recv_gate) else $error("receive request not gated");

	property p_any;
		@(posedge clock) disable iff (!rst_sync_b)
		serial_irq_request == |(flags & {enable_reg[ssc_pkg::CONFLICT_IE_POS], {2{enable_reg[ssc_pkg::RECV_IE_POS]}},
			enable_reg[ssc_pkg::XEND_IE_POS], enable_reg[ssc_pkg::XEMPTY_IE_POS]});
	endproperty
	a_any: assert property (p_any) else $error("combined request wrong");

	property p_sticky;
		@(posedge clock) disable iff (!rst_sync_b)
		(|rise) |=> (|irq_status);
	endproperty
	a_sticky: assert property (p_sticky) else $error("event not latched");

	property p_rx_enable;
		@(posedge clock) disable iff (!rst_sync_b)
		wr_enable |=> receive_enable == $past(bus.wdata[ssc_pkg::RECV_EN_POS]);
	endproperty
	a_rx_enable: assert property (p_rx_enable) else $error("receive enable not taken");

	property p_tx_enable;
		@(posedge clock) disable iff (!rst_sync_b)
		wr_enable |=> transmit_enable == $past(bus.wdata[ssc_pkg::XMIT_EN_POS]);
	endproperty
	a_tx_enable: assert property (p_tx_enable) else $error("transmit enable not taken");

	property p_conflict_block;
		@(posedge clock) disable iff (!rst_sync_b)
		!enable_reg[ssc_pkg::CONFLICT_IE_POS] && !flags.overrun && !flags.recv_full && !flags.xmit_end
			&& !flags.xmit_empty |-> !serial_irq_request;
	endproperty
	a_conflict_block: assert property (p_conflict_block) else $error("conflict request not blocked");

	property p_conflict_allow;
		@(posedge clock) disable iff (!rst_sync_b)
		flags.conflict && enable_reg[ssc_pkg::CONFLICT_IE_POS] |-> serial_irq_request;
	endproperty
	a_conflict_allow: assert property (p_conflict_allow) else $error("conflict request lost");

	property p_overrun_allow;
		@(posedge clock) disable iff (!rst_sync_b)
		flags.overrun && enable_reg[ssc_pkg::RECV_IE_POS] |-> serial_irq_request;
	endproperty
	a_overrun_allow: assert property (p_overrun_allow) else $error("overrun request lost");

	property p_full_allow;
		@(posedge clock) disable iff (!rst_sync_b)
		flags.recv_full && enable_reg[ssc_pkg::RECV_IE_POS] |-> serial_irq_request;
	endproperty
	a_full_allow: assert property (p_full_allow) else $error("receive full request lost");

	property p_end_block;
		@(posedge clock) disable iff (!rst_sync_b)
		!enable_reg[ssc_pkg::XEND_IE_POS] && !flags.conflict && !flags.overrun && !flags.recv_full
			&& !flags.xmit_empty |-> !serial_irq_request;
	endproperty
	a_end_block: assert property (p_end_block) else $error("transmit end request not blocked");

	property p_end_allow;
		@(posedge clock) disable iff (!rst_sync_b)
		flags.xmit_end && enable_reg[ssc_pkg::XEND_IE_POS] |-> serial_irq_request;
	endproperty
	a_end_allow: assert property (p_end_allow) else $error("transmit end request lost");

	property p_empty_block;
		@(posedge clock) disable iff (!rst_sync_b)
		!enable_reg[ssc_pkg::XEMPTY_IE_POS] && !flags.conflict && !flags.overrun && !flags.recv_full
			&& !flags.xmit_end |-> !serial_irq_request;
	endproperty
	a_empty_block: assert property (p_empty_block) else $error("transmit empty request not blocked");

	property p_empty_allow;
		@(posedge clock) disable iff (!rst_sync_b)
		flags.xmit_empty && enable_reg[ssc_pkg::XEMPTY_IE_POS] |-> serial_irq_request;
	endproperty
	a_empty_allow: assert property (p_empty_allow) else $error("transmit empty request lost");

	property p_no_flags;
		@(posedge clock) disable iff (!rst_sync_b)
		(flags == 5'h00) |-> !serial_irq_request;
	endproperty
	a_no_flags: assert property (p_no_flags) else $error("request without a flag");

	property p_reset_cause;
		@(posedge clock) disable iff (!rst_sync_b)
		engine_reset |-> $past(next_soft_reset);
	endproperty
	a_reset_cause: assert property (p_reset_cause) else $error("engine reset without a write");

	property p_no_spurious_reset;
		@(posedge clock) disable iff (!rst_sync_b)
		!next_soft_reset |=> !engine_reset;
	endproperty
	a_no_spurious_reset: assert property (p_no_spurious_reset) else $error("engine reset too long");

	property p_keep_idle;
		@(posedge clock) disable iff (!rst_sync_b)
		(next_soft_reset && !idle_write_ok) |=> $stable(idle_level);
	endproperty
	a_keep_idle: assert property (p_keep_idle) else $error("soft reset disturbed idle level");

	property p_keep_mask;
		@(posedge clock) disable iff (!rst_sync_b)
		(next_soft_reset && !wr_mask) |=> $stable(irq_mask);
	endproperty
	a_keep_mask: assert property (p_keep_mask) else $error("soft reset disturbed mask");

	property p_idle_update;
		@(posedge clock) disable iff (!rst_sync_b)
		idle_write_ok |=> idle_level == $past(bus.wdata[ssc_pkg::IDLE_LEVEL_POS]);
	endproperty
	a_idle_update: assert property (p_idle_update) else $error("permitted level write lost");

	property p_enable_store;
		@(posedge clock) disable iff (!rst_sync_b)
		wr_enable |=> enable_reg == ($past(bus.wdata) & ssc_pkg::ENABLE_USED_MASK);
	endproperty
	a_enable_store: assert property (p_enable_store) else $error("enable write stored wrong");

	property p_read_enable;
		@(posedge clock) disable iff (!rst_sync_b)
		(bus.read && bus.addr == ssc_pkg::ENABLE_OFFSET) |=> rdata == $past(enable_reg);
	endproperty
	a_read_enable: assert property (p_read_enable) else $error("enable read wrong");

	property p_ctrl_unused;
		@(posedge clock) disable iff (!rst_sync_b)
		(bus.read && bus.addr == ssc_pkg::CTRL_LOW_OFFSET) |=> rdata[7:6] == 2'b00 && rdata[3:0] == 4'h0;
	endproperty
	a_ctrl_unused: assert property (p_ctrl_unused) else $error("control read shows stray bits");

	// The pin follows the shifter only while a frame runs, so a mid-frame level write cannot glitch it
	property p_shift_pass;
		@(posedge clock) disable iff (!rst_sync_b)
		transfer_active |=> serial_data_out == $past(shift_data_out);
	endproperty
	a_shift_pass: assert property (p_shift_pass) else $error("shifter data not passed");

	property p_idle_hold;
		@(posedge clock) disable iff (!rst_sync_b)
		!transfer_active |=> serial_data_out == $past(idle_level);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle level not held");

	sequence s_plain_clear;
		wr_status && (rise == 5'h00);
	endsequence
	property p_status_clear;
		@(posedge clock) disable iff (!rst_sync_b)
		s_plain_clear |=> (irq_status & $past(bus.wdata[4:0])) == 5'h00;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status not cleared");

	// An event in the clearing cycle must survive, or software would miss it
	sequence s_set_and_clear;
		wr_status && ((rise & bus.wdata[4:0]) != 5'h00);
	endsequence
	property p_set_wins;
		@(posedge clock) disable iff (!rst_sync_b)
		s_set_and_clear |=> (irq_status & $past(rise)) == $past(rise);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");

	property p_rdata_quiet;
		@(posedge clock) disable iff (!rst_sync_b)
		!bus.read |=> rdata == 8'h00;
	endproperty
	a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data outside its cycle");
endmodule // ssc_regs
`default_nettype wire

// >>> verif/ssc_engine_model.sv
// Purpose: Shift engine stand-in driving transfer activity and shifter data
// Assumes: A go pulse with transmit enabled starts an 8-cycle frame
// Notes:   Data toggles every cycle so a stale value never passes
`default_nettype none
module ssc_engine_model (
	input  wire logic clock,
	input  wire logic go,
	input  wire logic engine_reset,
	input  wire logic transmit_enable,
	output logic      transfer_active,
	output logic      shift_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] count = 4'h0;
	assign transfer_active = count != 4'h0;
	always @(posedge clock) begin
		if (engine_reset) count <= 4'h0;
		else if (go && transmit_enable) count <= 4'h8;
		else if (count != 4'h0) count <= count - 4'h1;
		shift_data_out <= (shift_data_out === 1'b1) ? 1'b0 : 1'b1;
	end
endmodule // ssc_engine_model
`default_nettype wire

// >>> verif/sync_serial_ctrl_enable_regs_tb.sv
// Purpose: Self-checking bench for the control-low and enable registers
// Assumes: Flags driven by the bench, transfers by the engine model
// Notes:   Status sets only on a rising gated request
`default_nettype none
module sync_serial_ctrl_enable_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic go = 1'b0;
	ssc_pkg::ssc_bus_type bus = '0;
	ssc_pkg::ssc_flags_type flags = '0;
	logic [7:0] rdata;
	logic ta, sdi, sdo, eng_rst, rx_en, tx_en, req, irq;
	int n_fail = 0;
	int comparisons = 0;
	ssc_regs ssc_regs_inst (.clock(clock), .rst_b(rst_b), .bus(bus), .rdata(rdata), .flags(flags),
		.transfer_active(ta), .shift_data_out(sdi), .serial_data_out(sdo), .engine_reset(eng_rst),
		.receive_enable(rx_en), .transmit_enable(tx_en), .serial_irq_request(req), .irq(irq));
	ssc_engine_model ssc_engine_model_inst (.clock(clock), .go(go), .engine_reset(eng_rst),
		.transmit_enable(tx_en), .transfer_active(ta), .shift_data_out(sdi));
	initial forever #10 clock = ~clock;
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clock) bus.write <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
		@(posedge clock) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock) bus.read <= 1'b0;
		#1 check(rdata, exp, msg);
	endtask
	task automatic summarize();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_reset();
		rd(ssc_pkg::CTRL_LOW_OFFSET, 8'h30, "ctrl reset");
		rd(ssc_pkg::ENABLE_OFFSET, ssc_pkg::ENABLE_RESET, "enable reset");
		rd(ssc_pkg::IRQ_MASK_OFFSET, ssc_pkg::IRQ_MASK_RESET, "mask reset");
		rd(8'h55, 8'h00, "unmapped");
		$display("test reset done");
	endtask
	task automatic t_enable();
		wr(ssc_pkg::ENABLE_OFFSET, 8'hFF);
		check({6'h00, rx_en, tx_en}, 8'h03, "enables on");
		rd(ssc_pkg::ENABLE_OFFSET, ssc_pkg::ENABLE_USED_MASK, "unused bits");
		wr(ssc_pkg::ENABLE_OFFSET, 8'h10);
		check({6'h00, rx_en, tx_en}, 8'h01, "rx off");
		$display("test enable done");
	endtask
	task automatic t_idle();
		wr(ssc_pkg::CTRL_LOW_OFFSET, 8'h10);
		@(posedge clock) #1 check({7'h00, sdo}, 8'h01, "protected write");
		wr(ssc_pkg::CTRL_LOW_OFFSET, 8'h00);
		@(posedge clock) #1 check({7'h00, sdo}, 8'h00, "idle low");
		rd(ssc_pkg::CTRL_LOW_OFFSET, 8'h10, "read low");
		wr(ssc_pkg::CTRL_LOW_OFFSET, 8'h20);
		rd(ssc_pkg::CTRL_LOW_OFFSET, 8'h30, "read high");
		$display("test idle done");
	endtask
	task automatic t_soft();
		int k;
		@(posedge clock) go <= 1'b1;
		@(posedge clock) go <= 1'b0;
		for (k = 0; k < 4 && ta !== 1'b1; k++) @(posedge clock);
		if (k == 4) begin
			n_fail++;
			summarize();
		end
		@(posedge clock) #1 check({7'h00, sdo}, {7'h00, ~sdi}, "shifter data");
		wr(ssc_pkg::CTRL_LOW_OFFSET, 8'h12);
		check({7'h00, eng_rst}, 8'h01, "reset pulse");
		@(posedge clock) #1 check({6'h00, eng_rst, ta}, 8'h00, "frame aborted");
		rd(ssc_pkg::ENABLE_OFFSET, 8'h10, "enable kept");
		rd(ssc_pkg::CTRL_LOW_OFFSET, 8'h30, "level kept");
		$display("test soft reset done");
	endtask
	task automatic t_gate();
		int en [5] = '{ssc_pkg::CONFLICT_IE_POS, ssc_pkg::RECV_IE_POS, ssc_pkg::RECV_IE_POS,
			ssc_pkg::XEND_IE_POS, ssc_pkg::XEMPTY_IE_POS};
		for (int i = 0; i < 5; i++) begin
			wr(ssc_pkg::ENABLE_OFFSET, 8'h00);
			@(posedge clock) flags <= 5'h10 >> i;
			@(posedge clock) #1 check({7'h00, req}, 8'h00, "blocked");
			wr(ssc_pkg::ENABLE_OFFSET, 8'h01 << en[i]);
			check({7'h00, req}, 8'h01, "allowed");
			@(posedge clock) flags <= '0;
		end
		$display("test gating done");
	endtask
	task automatic t_irq();
		wr(ssc_pkg::ENABLE_OFFSET, 8'h40);
		wr(ssc_pkg::IRQ_STATUS_OFFSET, 8'h1F);
		@(posedge clock) flags.xmit_end <= 1'b1;
		repeat (2) @(posedge clock);
		#1 check({7'h00, irq}, 8'h00, "masked");
		wr(ssc_pkg::IRQ_MASK_OFFSET, 8'h08);
		check({7'h00, irq}, 8'h01, "unmasked");
		@(posedge clock) flags <= '0;
		wr(ssc_pkg::IRQ_STATUS_OFFSET, 8'h08);
		rd(ssc_pkg::IRQ_STATUS_OFFSET, 8'h00, "cleared");
		check({7'h00, irq}, 8'h00, "irq low");
		$display("test irq done");
	endtask
	initial begin
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		repeat (5) @(posedge clock);
		t_reset();
		t_enable();
		t_idle();
		t_soft();
		t_gate();
		t_irq();
		summarize();
	end
endmodule // sync_serial_ctrl_enable_regs_tb
`default_nettype wire
